// ### hdl/iprc_top.sv
// interrupt priority control with an AXI4-Lite register port
`timescale 1ns/1ns
module iprc_top #(
  parameter int N = 8
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             ce,
  input  wire logic [N-1:0]     irqReq,
  input  wire logic [N-1:0]     irqEnable,
  output logic                  serviceHigh_q,
  output logic                  serviceLow_q,
  output logic [2:0]            serviceIdx_q,
  output logic                  masterIrqEnable_q,
  input  wire logic [15:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [15:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);

  // ==========================================================================
  // priority register state
  logic [2:0]  prioSel_q;
  logic        awHeld_q;
  logic        wHeld_q;
  logic [15:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        doWrite;
  logic        hitPrio;
  logic        hitMen;
  logic        hitStatus;

  iprc_res_if #(.N(N)) resBus ();

  assign resBus.req          = irqReq;
  assign resBus.enable       = irqEnable;
  assign resBus.masterEnable = masterIrqEnable_q;
  assign resBus.sel          = prioSel_q;

  iprc_resolver #(.N(N)) u_res (
    .r (resBus)
  );

  // ==========================================================================
  // write address and data capture, either order
  assign doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
  assign hitPrio = (awAddr_q == iprc_pkg::PRIO_REG_ADDR);
  assign hitMen  = (awAddr_q == iprc_pkg::MEN_BIT_ADDR);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld_q      <= 1'b0;
      awAddr_q      <= 16'h0000;
      s_axi_awready <= 1'b1;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q      <= 1'b1;
        awAddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wHeld_q      <= 1'b0;
      wData_q      <= 32'h0000_0000;
      wStrb_q      <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q      <= 1'b1;
        wData_q      <= s_axi_wdata;
        wStrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // write response
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= iprc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (hitPrio || hitMen) ? iprc_pkg::RESP_OKAY : iprc_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // priority register: nibble access writes all, bit access only the enable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      masterIrqEnable_q <= iprc_pkg::PRIO_RESET[iprc_pkg::MEN_BIT];
      prioSel_q         <= iprc_pkg::PRIO_RESET[2:0];
    end else if (ce && doWrite && wStrb_q[0]) begin
      if (hitPrio) begin
        masterIrqEnable_q <= wData_q[iprc_pkg::MEN_BIT];
        prioSel_q         <= wData_q[iprc_pkg::SEL_LSB +: iprc_pkg::SEL_W];
      end else if (hitMen) begin
        masterIrqEnable_q <= wData_q[0];
      end
    end
  end

  // ==========================================================================
  // read channel; the priority register is write-only and reads as zero
  assign hitStatus = (s_axi_araddr == iprc_pkg::STATUS_ADDR);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= iprc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= iprc_pkg::RESP_OKAY;
        if (hitStatus) begin
          s_axi_rdata <= {8'h00, resBus.loActive, resBus.hiActive,
                          4'h0, masterIrqEnable_q, prioSel_q};
        end else if (s_axi_araddr == iprc_pkg::PRIO_REG_ADDR ||
                     s_axi_araddr == iprc_pkg::MEN_BIT_ADDR) begin
          s_axi_rdata <= 32'h0000_0000;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= iprc_pkg::RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // service selection: any high request beats all low ones
  logic [2:0] pickIdx;
  logic       anyHigh;
  logic       anyLow;

  always_comb begin
    pickIdx = 3'h0;
    anyHigh = |resBus.hiActive;
    anyLow  = |resBus.loActive;
    // lowest index wins inside a group; scan downward so it ends last
    for (int k = N - 1; k >= 0; k--) begin
      if (anyHigh ? resBus.hiActive[k] : resBus.loActive[k]) begin
        pickIdx = 3'(k);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      serviceHigh_q <= 1'b0;
      serviceLow_q  <= 1'b0;
      serviceIdx_q  <= 3'h0;
    end else if (ce) begin
      serviceHigh_q <= anyHigh;
      serviceLow_q  <= anyLow & ~anyHigh;
      serviceIdx_q  <= pickIdx;
    end
  end

endmodule

// ### hdl/iprc_pkg.sv
// constants and types for the interrupt priority control block
// Notes on behaviour
// - master enable at 0 blocks every interrupt request from being processed.
// - master enable at 1 lets each enabled request through at its priority.
// - priority field 000 puts every source at low priority.
// - field 001 raises basic timer and external four together.
// - field 010 raises external zero only; 011 raises external one only.
// - fields 100 to 111 raise serial, timer zero, timer one, key.
// - master enable writable by bit or nibble access; priority bits nibble only.
package iprc_pkg;

  // ==========================================================================
  // register map
  localparam logic [11:0] PRIO_REG_INDEX = 12'h0fb2;
  localparam logic [15:0] PRIO_REG_ADDR  = {2'b00, PRIO_REG_INDEX, 2'b00};
  localparam logic [15:0] MEN_BIT_ADDR   = 16'h0000;
  localparam logic [15:0] STATUS_ADDR    = 16'h0004;
  localparam int          ADDR_W         = 16;

  // ==========================================================================
  // field layout and reset values
  localparam int          MEN_BIT        = 3;
  localparam int          SEL_LSB        = 0;
  localparam int          SEL_W          = 3;
  localparam logic [3:0]  PRIO_RESET     = 4'h0;
  localparam int          NUM_SRC        = 8;

  // ==========================================================================
  // source indices
  localparam int SRC_BASIC_TIMER = 0;
  localparam int SRC_EXT_FOUR    = 1;
  localparam int SRC_EXT_ZERO    = 2;
  localparam int SRC_EXT_ONE     = 3;
  localparam int SRC_SERIAL      = 4;
  localparam int SRC_TIMER_ZERO  = 5;
  localparam int SRC_TIMER_ONE   = 6;
  localparam int SRC_KEY         = 7;

  // ==========================================================================
  // priority field encodings
  typedef enum logic [2:0] {
    IPRC_SEL_NONE        = 3'b000,
    IPRC_SEL_TIMER_EXT4  = 3'b001,
    IPRC_SEL_EXT_ZERO    = 3'b010,
    IPRC_SEL_EXT_ONE     = 3'b011,
    IPRC_SEL_SERIAL      = 3'b100,
    IPRC_SEL_TIMER_ZERO  = 3'b101,
    IPRC_SEL_TIMER_ONE   = 3'b110,
    IPRC_SEL_KEY         = 3'b111
  } iprc_sel_t;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ### hdl/iprc_res_if.sv
// link between the register side and the priority resolver
`timescale 1ns/1ns
interface iprc_res_if #(parameter int N = 8);
  logic [N-1:0] req;
  logic [N-1:0] enable;
  logic         masterEnable;
  logic [2:0]   sel;
  logic [N-1:0] hiActive;
  logic [N-1:0] loActive;

  modport ctrl (output req, output enable, output masterEnable, output sel,
                input hiActive, input loActive);
  modport res  (input req, input enable, input masterEnable, input sel,
                output hiActive, output loActive);
endinterface

// ### hdl/iprc_resolver.sv
// splits enabled requests into high and low priority groups
`timescale 1ns/1ns
module iprc_resolver #(
  parameter int N = 8
) (
  iprc_res_if.res r
);

  // ==========================================================================
  // per-source priority class
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_src
      logic isHigh;
      logic live;
      // the pair case is the only code that lifts two sources at once
      if (i == iprc_pkg::SRC_BASIC_TIMER || i == iprc_pkg::SRC_EXT_FOUR) begin : g_pair
        assign isHigh = (r.sel == iprc_pkg::IPRC_SEL_TIMER_EXT4);
      end else begin : g_single
        assign isHigh = (r.sel == 3'(i));
      end
      assign live          = r.req[i] & r.enable[i] & r.masterEnable;
      assign r.hiActive[i] = live & isHigh;
      assign r.loActive[i] = live & ~isHigh;
    end
  endgenerate

endmodule

// ### verification/iprc_chk_sva.sv
// concurrent checks on the interrupt priority control ports
`timescale 1ns/1ns
module iprc_chk #(parameter int N = 8) (
  input wire logic         clk,
  input wire logic         arst_n,
  input wire logic [N-1:0] irqReq,
  input wire logic [N-1:0] irqEnable,
  input wire logic         serviceHigh_q,
  input wire logic         serviceLow_q,
  input wire logic [2:0]   serviceIdx_q,
  input wire logic         masterIrqEnable_q,
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic         s_axi_wvalid,
  input wire logic         s_axi_wready,
  input wire logic         s_axi_bvalid
);
  // ==========================================================
  // helper: lowest live source, the order inside the low group
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [N-1:0] live;
  logic [2:0]   lowIdx_q;
  assign live = irqReq & irqEnable;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      lowIdx_q <= 3'h0;
    else begin
      lowIdx_q <= 3'h0;
      for (int i = N - 1; i >= 0; i--)
        if (live[i]) lowIdx_q <= 3'(i);
    end
  end
  sequence wTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence noneServed;
    !serviceHigh_q && !serviceLow_q;
  endsequence
  AST_MEN_OFF: assert property (!masterIrqEnable_q |=> noneServed)
    else $error("served with master off");
  AST_SERVED: assert property (masterIrqEnable_q && (|live) |=> serviceHigh_q || serviceLow_q)
    else $error("live request not served");
  AST_IDLE: assert property (!(|live) |=> noneServed ##0 serviceIdx_q == 3'h0)
    else $error("served with nothing live");
  AST_LOW_ORDER: assert property (serviceLow_q |-> serviceIdx_q == lowIdx_q)
    else $error("wrong low index");
  AST_WR_ANSWER: assert property (wTaken |-> ##[1:3] s_axi_bvalid)
    else $error("no write response");
  AST_B_BUSY: assert property ($rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
    else $error("ready during response");
  AST_MEN_BY_WRITE: assert property ($changed(masterIrqEnable_q) |-> $rose(s_axi_bvalid))
    else $error("enable moved without write");
  AST_RESET_CLEAR: assert property ($rose(arst_n) |-> !masterIrqEnable_q && s_axi_awready)
    else $error("not clear after reset");
endmodule
bind iprc_top iprc_chk #(.N(N)) iprc_chk_i (.clk, .arst_n, .irqReq, .irqEnable, .serviceHigh_q,
  .serviceLow_q, .serviceIdx_q, .masterIrqEnable_q, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid);

// ### verification/iprc_src_model.sv
// interrupt source model giving request and enable levels
`timescale 1ns/1ns
module iprc_src_model #(parameter int N = 8) (
  input  wire logic         clk,
  input  wire logic [N-1:0] reqSet,
  input  wire logic [N-1:0] enSet,
  output logic      [N-1:0] irqReq = '0,
  output logic      [N-1:0] irqEnable = '0
);
  // ==========================================================
  // sources move only on an edge, like synchronous peripherals
  always @(posedge clk) begin
    irqReq    <= reqSet;
    irqEnable <= enSet;
  end
endmodule

// ### verification/tb_interrupt_priority_control.sv
// self-checking bench for the interrupt priority control block
`timescale 1ns/1ns
module tb_interrupt_priority_control;
  logic        clk = 1'b0, arst_n = 1'b0;
  logic [7:0]  reqSet = 8'h00, enSet = 8'h00, irqReq, irqEnable;
  logic        serviceHigh_q, serviceLow_q, masterIrqEnable_q;
  logic [2:0]  serviceIdx_q;
  logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd, e;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        ce = 1'b1;
  int          miscompares = 0, nTests = 0;
  initial forever #5 clk = ~clk;
  iprc_src_model #(.N(8)) iprc_src_model_i (.clk, .reqSet, .enSet, .irqReq, .irqEnable);
  iprc_top #(.N(8)) iprc_top_i (.clk, .arst_n, .ce, .irqReq, .irqEnable, .serviceHigh_q,
    .serviceLow_q, .serviceIdx_q, .masterIrqEnable_q, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // ==========================================================
  // bus cycles and comparison
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [15:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    axi_rd(iprc_pkg::STATUS_ADDR);
    chk(rd, 32'h0000_0000);
    axi_rd(iprc_pkg::PRIO_REG_ADDR);
    chk(32'(rsp), 32'(iprc_pkg::RESP_OKAY));
    axi_rd(16'h0008);
    chk(32'(rsp), 32'(iprc_pkg::RESP_SLVERR));
    $display("reset test done");
  endtask
  task automatic t_fields;
    logic [7:0] hi;
    @(posedge clk);
    reqSet <= 8'hFF;
    enSet <= 8'hFF;
    for (int f = 0; f < 8; f++) begin
      hi = (f == 0) ? 8'h00 : (f == 1) ? 8'h03 : 8'(1 << f);
      axi_wr(iprc_pkg::PRIO_REG_ADDR, 32'(8 + f), 4'h1);
      chk(32'(rsp), 32'(iprc_pkg::RESP_OKAY));
      repeat (2) @(posedge clk);
      #1;
      e = 32'({f != 0, f == 0, (f < 2) ? 3'h0 : 3'(f)});
      chk(32'({serviceHigh_q, serviceLow_q, serviceIdx_q}), e);
      axi_rd(iprc_pkg::STATUS_ADDR);
      chk(rd, {8'h00, ~hi, hi, 5'h01, 3'(f)});
    end
    $display("field test done");
  endtask
  task automatic t_bits;
    axi_wr(iprc_pkg::MEN_BIT_ADDR, 32'h0000_0000, 4'h1);
    repeat (2) @(posedge clk);
    #1;
    chk(32'({serviceHigh_q, serviceLow_q}), 32'h0000_0000);
    chk(32'(masterIrqEnable_q), 32'h0000_0000);
    axi_rd(iprc_pkg::STATUS_ADDR);
    chk(32'(rd[3:0]), 32'h0000_0007);
    axi_wr(iprc_pkg::PRIO_REG_ADDR, 32'h0000_000C, 4'h0);
    chk(32'(rsp), 32'(iprc_pkg::RESP_OKAY));
    axi_wr(16'h0010, 32'h0000_000C, 4'hF);
    chk(32'(rsp), 32'(iprc_pkg::RESP_SLVERR));
    axi_wr(iprc_pkg::MEN_BIT_ADDR, 32'h0000_0001, 4'h1);
    axi_rd(iprc_pkg::STATUS_ADDR);
    chk(32'(rd[3:0]), 32'h0000_000F);
    chk(32'(masterIrqEnable_q), 32'h0000_0001);
    $display("bit access test done");
  endtask
  // service outputs must hold while the clock enable is low, then catch up
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    reqSet <= 8'h01;
    repeat (3) @(posedge clk);
    #1;
    chk(32'({serviceHigh_q, serviceLow_q, serviceIdx_q}), 32'h0000_0017);
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(32'({serviceHigh_q, serviceLow_q, serviceIdx_q}), 32'h0000_0008);
    $display("clock enable test done");
  endtask
  // a reset in mid-run must clear a register that software had set
  task automatic t_rearm;
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk(32'({masterIrqEnable_q, serviceHigh_q, serviceLow_q}), 32'h0000_0000);
    axi_rd(iprc_pkg::STATUS_ADDR);
    chk(rd, 32'h0000_0000);
    $display("mid-run reset test done");
  endtask
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // about 125 cycles are expected; this cuts a hang short
  initial begin
    #50000;
    miscompares++;
    close_out;
  end
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_reset;
    t_fields;
    t_bits;
    t_freeze;
    t_rearm;
    close_out;
  end
endmodule
